// ### src/mbp_mailbox.sv
// Purpose: One mail register with its full flag
// Assumes: rst_b covers every kind of reset
// Notes: Lane-limited capture
module mbp_mailbox (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr,
  input wire logic rd,
  input wire mbp_pkg::mbp_size_e size,
  input wire mbp_pkg::mbp_word_t wr_data,
  output mbp_pkg::mbp_word_t data,
  output logic full_n
);
  import mbp_pkg::*;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      full_n <= 1'b1;
    end else if (wr && full_n) begin
      full_n <= 1'b0;
    end else if (rd) begin
      full_n <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      data <= '0;
    end else if (wr && full_n) begin
      data <= wr_data & mbp_lanes(size);
    end
  end
endmodule : mbp_mailbox

// ### src/mbp_map.svh
// Purpose: Constants for the mailbox and bus-matching port block
// Assumes: One clock for both ports
// Notes: Widths, delays and reset values
//
// Summary of operation
// - B-to-A mail captures B lines 0-17 or 0-8 when sized narrower.
// - An accepted mail write drives that mailbox full flag low.
// - Writes to a mailbox with full flag low are dropped.
// - Enabled Port B outputs show FIFO output when mail select low, mailbox when high; Port A shows zero when low.
// - Port B mail read returns the A-to-B full flag high.
// - Port B mail read shows 36, 18 or 9 lines by size.
// - Port A mail read returns the B-to-A full flag high.
// - Port A mail read shows 36, 18 or 9 lines by size.
// - Reading a mailbox keeps its contents.
// - Mail ignores endian and piece sequencing.
// - Port B width 36, 18 or 9; bus-match low forces 36.
// - Size and endian take effect by the time the input flag rises.
// - Endian select captured on rising full reset; big sends top first.
// - Endian select has no effect in long-word size.
// - Memory keeps 36-bit words; narrowing after memory; mail lane-limited.
// - Long word moves whole; narrow sizes hold the rest for later reads.
// - Unused Port B lines in narrow FIFO reads carry no data.
// - Fall-through high drops the output flag one cycle earlier in reset.
// - FIFO writes are dropped until the input flag rises.
// - Word size: big gives upper half first, little lower half.
// - Byte size: four bytes; big from top down, little from bottom up.
// - Port A mail write loads the A-to-B mailbox.
// - Port B mail write loads the B-to-A mailbox.
`ifndef MBP_MAP_SVH
`define MBP_MAP_SVH
`define MBP_WIDTH 36
`define MBP_HALF_W 18
`define MBP_BYTE_W 9
`define MBP_RESET_CYCLES 3'h4
`define MBP_EF_FAST_DELAY 2'h1
`define MBP_EF_SLOW_DELAY 2'h2
`define MBP_BUF_DEPTH 2'h2
`endif

// ### src/mbp_pkg.sv
// Purpose: Shared types for the mailbox and bus-matching block
// Assumes: mbp_map.svh holds the numbers
// Notes: Lane mask helper used by mail paths
`include "mbp_map.svh"
package mbp_pkg;
  typedef logic [`MBP_WIDTH-1:0] mbp_word_t;
  typedef enum logic [1:0] {MBP_LONG, MBP_HALF, MBP_BYTE} mbp_size_e;

  function automatic mbp_word_t mbp_lanes(input mbp_size_e size);
    mbp_word_t m;
    m = '1;
    if (size == MBP_HALF) begin
      m = {{(`MBP_WIDTH-`MBP_HALF_W){1'b0}}, {`MBP_HALF_W{1'b1}}};
    end else if (size == MBP_BYTE) begin
      m = {{(`MBP_WIDTH-`MBP_BYTE_W){1'b0}}, {`MBP_BYTE_W{1'b1}}};
    end
    return m;
  endfunction : mbp_lanes
endpackage : mbp_pkg

// ### src/mbp_port.sv
// Purpose: Mailbox bypass and Port B bus matching
// Assumes: Both ports on CLOCK, inputs synchronous
// Notes: Data outputs are registered on the selecting edge itself
`include "mbp_map.svh"
module mbp_port (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic FULL_RESET_N,
  input wire logic PARTIAL_CLEAR_N,
  input wire logic BUS_WIDTH_MATCH_SEL,
  input wire logic BYTE_SIZE_SEL,
  input wire logic BIG_ENDIAN_SEL,
  input wire logic PORT_A_SELECT_N,
  input wire logic PORT_A_DIR,
  input wire logic PORT_A_STROBE,
  input wire logic PORT_A_MAIL_SEL,
  input wire mbp_pkg::mbp_word_t PORT_A_DATA_IN,
  output mbp_pkg::mbp_word_t PORT_A_DATA_OUT,
  output logic PORT_A_DATA_OE,
  input wire logic PORT_B_SELECT_N,
  input wire logic PORT_B_DIR,
  input wire logic PORT_B_STROBE,
  input wire logic PORT_B_MAIL_SEL,
  input wire mbp_pkg::mbp_word_t PORT_B_DATA_IN,
  output mbp_pkg::mbp_word_t PORT_B_DATA_OUT,
  output logic PORT_B_DATA_OE,
  output logic MAIL_AB_FULL_N,
  output logic MAIL_BA_FULL_N,
  output logic FULL_OR_IN_READY,
  output logic EMPTY_OR_OUT_READY,
  output mbp_pkg::mbp_word_t FIFO_WR_DATA,
  output logic FIFO_WR_VALID,
  input wire logic FIFO_WR_READY,
  input wire mbp_pkg::mbp_word_t MEM_WORD,
  input wire logic MEM_VALID,
  output logic MEM_READY
);
  import mbp_pkg::*;

  // Reset and configuration state
  logic any_reset;
  logic mb_rst_b;
  logic full_reset_q;
  logic [2:0] rst_cnt;
  logic [1:0] rst_age;
  logic [1:0] ef_delay;
  logic cfg_big_endian;
  logic big_endian_sel;
  logic fall_through_mode;
  mbp_size_e cfg_size;
  mbp_size_e pin_size;

  // Port decodes
  logic a_write;
  logic a_read;
  logic b_write;
  logic b_read;
  logic a_fifo_write;
  logic b_fifo_read;

  // Mailboxes
  mbp_word_t a_to_b_mailbox;
  mbp_word_t b_to_a_mailbox;
  logic mail_ab_full_n;
  logic mail_ba_full_n;

  // Bus matching state
  mbp_word_t hold_word;
  logic [1:0] piece_idx;
  logic [1:0] pieces_left;
  mbp_word_t out_reg;
  logic out_valid;
  mbp_word_t next_out_reg;
  logic next_out_valid;
  mbp_word_t next_hold_word;
  logic [1:0] next_piece_idx;
  logic [1:0] next_pieces_left;
  logic take;
  logic pop;

  mbp_stream_if mem_s ();
  mbp_stream_if buf_s ();

  // Shared endian and fall-through pin
  assign big_endian_sel = BIG_ENDIAN_SEL;
  assign fall_through_mode = BIG_ENDIAN_SEL;

  assign any_reset = !FULL_RESET_N || !PARTIAL_CLEAR_N;
  assign mb_rst_b = RST_B && !any_reset;

  // Width from the select pins
  always_comb begin
    if (!BUS_WIDTH_MATCH_SEL) begin
      pin_size = MBP_LONG;
    end else if (BYTE_SIZE_SEL) begin
      pin_size = MBP_BYTE;
    end else begin
      pin_size = MBP_HALF;
    end
  end

  assign a_write = !PORT_A_SELECT_N && !PORT_A_DIR && PORT_A_STROBE;
  assign a_read = !PORT_A_SELECT_N && PORT_A_DIR && PORT_A_STROBE;
  assign b_write = !PORT_B_SELECT_N && !PORT_B_DIR && PORT_B_STROBE;
  assign b_read = !PORT_B_SELECT_N && PORT_B_DIR && PORT_B_STROBE;
  assign a_fifo_write = a_write && !PORT_A_MAIL_SEL && FULL_OR_IN_READY;
  assign b_fifo_read = b_read && !PORT_B_MAIL_SEL && out_valid;

  // Endian captured on the rising full reset edge
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      full_reset_q <= 1'b1;
    end else begin
      full_reset_q <= FULL_RESET_N;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      cfg_big_endian <= 1'b0;
    end else if (!full_reset_q && FULL_RESET_N) begin
      cfg_big_endian <= big_endian_sel;
    end
  end

  // Reset completion counter
  always_ff @(posedge CLOCK) begin
    if (!RST_B || any_reset) begin
      rst_cnt <= 3'h0;
    end else if (rst_cnt != `MBP_RESET_CYCLES) begin
      rst_cnt <= rst_cnt + 3'h1;
    end
  end

  // Size latched one cycle before the input flag can rise
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      cfg_size <= MBP_LONG;
    end else if (!any_reset && rst_cnt == `MBP_RESET_CYCLES - 3'h1) begin
      cfg_size <= pin_size;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B || any_reset) begin
      FULL_OR_IN_READY <= 1'b0;
    end else begin
      FULL_OR_IN_READY <= (rst_cnt == `MBP_RESET_CYCLES) && FIFO_WR_READY;
    end
  end

  // FIFO write path from Port A
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      FIFO_WR_VALID <= 1'b0;
      FIFO_WR_DATA <= '0;
    end else begin
      FIFO_WR_VALID <= a_fifo_write;
      if (a_fifo_write) begin
        FIFO_WR_DATA <= PORT_A_DATA_IN;
      end
    end
  end

  // Mail registers
  mbp_mailbox u_mail_ab (
    .clk(CLOCK),
    .rst_b(mb_rst_b),
    .wr(a_write && PORT_A_MAIL_SEL),
    .rd(b_read && PORT_B_MAIL_SEL),
    .size(cfg_size),
    .wr_data(PORT_A_DATA_IN),
    .data(a_to_b_mailbox),
    .full_n(mail_ab_full_n)
  );

  mbp_mailbox u_mail_ba (
    .clk(CLOCK),
    .rst_b(mb_rst_b),
    .wr(b_write && PORT_B_MAIL_SEL),
    .rd(a_read && PORT_A_MAIL_SEL),
    .size(cfg_size),
    .wr_data(PORT_B_DATA_IN),
    .data(b_to_a_mailbox),
    .full_n(mail_ba_full_n)
  );

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      MAIL_AB_FULL_N <= 1'b1;
      MAIL_BA_FULL_N <= 1'b1;
    end else begin
      MAIL_AB_FULL_N <= mail_ab_full_n;
      MAIL_BA_FULL_N <= mail_ba_full_n;
    end
  end

  // Memory word path through the two-entry buffer
  assign mem_s.valid = MEM_VALID;
  assign mem_s.data = MEM_WORD;
  assign MEM_READY = mem_s.ready;

  mbp_skid_buf u_buf (
    .clk(CLOCK),
    .rst_b(RST_B),
    .clear(any_reset),
    .in_s(mem_s.snk),
    .out_s(buf_s.src)
  );

  // Select one piece of a long word
  function automatic mbp_word_t piece(input mbp_word_t w, input mbp_size_e sz,
                                      input logic be, input logic [1:0] idx);
    logic [1:0] sel;
    mbp_word_t r;
    sel = 2'h0;
    r = '0;
    unique case (sz)
      MBP_LONG: begin
        r = w;
      end
      MBP_HALF: begin
        sel = be ? {1'b0, ~idx[0]} : {1'b0, idx[0]};
        r[`MBP_HALF_W-1:0] = sel[0] ? w[`MBP_WIDTH-1:`MBP_HALF_W] : w[`MBP_HALF_W-1:0];
      end
      MBP_BYTE: begin
        sel = be ? (2'h3 - idx) : idx;
        unique case (sel)
          2'h0: r[`MBP_BYTE_W-1:0] = w[8:0];
          2'h1: r[`MBP_BYTE_W-1:0] = w[17:9];
          2'h2: r[`MBP_BYTE_W-1:0] = w[26:18];
          2'h3: r[`MBP_BYTE_W-1:0] = w[35:27];
        endcase
      end
      default: begin
        r = w;
      end
    endcase
    return r;
  endfunction : piece

  // Number of pieces per long word, less one
  function automatic logic [1:0] extra(input mbp_size_e sz);
    logic [1:0] n;
    n = 2'h0;
    if (sz == MBP_HALF) begin
      n = 2'h1;
    end else if (sz == MBP_BYTE) begin
      n = 2'h3;
    end
    return n;
  endfunction : extra

  // Output register refill
  assign take = !out_valid || b_fifo_read;
  assign pop = take && (pieces_left == 2'h0) && buf_s.valid;
  assign buf_s.ready = take && (pieces_left == 2'h0);

  always_comb begin
    next_out_reg = out_reg;
    next_out_valid = out_valid;
    next_hold_word = hold_word;
    next_piece_idx = piece_idx;
    next_pieces_left = pieces_left;
    if (take) begin
      if (pieces_left != 2'h0) begin
        next_out_reg = piece(hold_word, cfg_size, cfg_big_endian, piece_idx);
        next_out_valid = 1'b1;
        next_piece_idx = piece_idx + 2'h1;
        next_pieces_left = pieces_left - 2'h1;
      end else if (buf_s.valid) begin
        next_out_reg = piece(buf_s.data, cfg_size, cfg_big_endian, 2'h0);
        next_out_valid = 1'b1;
        next_hold_word = buf_s.data;
        next_piece_idx = 2'h1;
        next_pieces_left = extra(cfg_size);
      end else begin
        next_out_valid = 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B || any_reset) begin
      out_reg <= '0;
      out_valid <= 1'b0;
      hold_word <= '0;
      piece_idx <= 2'h0;
      pieces_left <= 2'h0;
    end else begin
      out_reg <= next_out_reg;
      out_valid <= next_out_valid;
      hold_word <= next_hold_word;
      piece_idx <= next_piece_idx;
      pieces_left <= next_pieces_left;
    end
  end

  // Output flag, early drop under fall-through during reset
  assign ef_delay = fall_through_mode ? `MBP_EF_FAST_DELAY : `MBP_EF_SLOW_DELAY;

  always_ff @(posedge CLOCK) begin
    if (!RST_B || !any_reset) begin
      rst_age <= 2'h0;
    end else if (rst_age != 2'h3) begin
      rst_age <= rst_age + 2'h1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      EMPTY_OR_OUT_READY <= 1'b0;
    end else if (any_reset) begin
      if (rst_age + 2'h1 >= ef_delay) begin
        EMPTY_OR_OUT_READY <= 1'b0;
      end
    end else begin
      EMPTY_OR_OUT_READY <= next_out_valid;
    end
  end

  // Port A data outputs
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      PORT_A_DATA_OE <= 1'b0;
      PORT_A_DATA_OUT <= '0;
    end else begin
      PORT_A_DATA_OE <= !PORT_A_SELECT_N && PORT_A_DIR;
      if (PORT_A_MAIL_SEL) begin
        PORT_A_DATA_OUT <= b_to_a_mailbox & mbp_lanes(cfg_size);
      end else begin
        PORT_A_DATA_OUT <= '0;
      end
    end
  end

  // Port B data outputs
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      PORT_B_DATA_OE <= 1'b0;
      PORT_B_DATA_OUT <= '0;
    end else begin
      PORT_B_DATA_OE <= !PORT_B_SELECT_N && PORT_B_DIR;
      if (PORT_B_MAIL_SEL) begin
        PORT_B_DATA_OUT <= a_to_b_mailbox & mbp_lanes(cfg_size);
      end else begin
        PORT_B_DATA_OUT <= out_reg;
      end
    end
  end
endmodule : mbp_port

// ### src/mbp_skid_buf.sv
// Purpose: Two-entry buffer on the memory word path
// Assumes: Synchronous active-low reset, clear flushes
// Notes: Input ready is registered
`include "mbp_map.svh"
module mbp_skid_buf (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  mbp_stream_if.snk in_s,
  mbp_stream_if.src out_s
);
  import mbp_pkg::*;
  mbp_word_t slot0;
  mbp_word_t slot1;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic in_rdy;
  logic push;
  logic pop;

  assign push = in_s.valid && in_rdy;
  assign pop = (cnt != 2'h0) && out_s.ready;
  assign in_s.ready = in_rdy;
  assign out_s.valid = (cnt != 2'h0);
  assign out_s.data = slot0;
  assign next_cnt = cnt + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk) begin
    if (!rst_b || clear) begin
      cnt <= 2'h0;
      in_rdy <= 1'b0;
    end else begin
      cnt <= next_cnt;
      in_rdy <= (next_cnt != `MBP_BUF_DEPTH);
    end
  end

  always_ff @(posedge clk) begin
    if (pop && push) begin
      slot0 <= (cnt == 2'h1) ? in_s.data : slot1;
      slot1 <= in_s.data;
    end else if (pop) begin
      slot0 <= slot1;
    end else if (push) begin
      if (cnt == 2'h0) begin
        slot0 <= in_s.data;
      end else begin
        slot1 <= in_s.data;
      end
    end
  end
endmodule : mbp_skid_buf

// ### src/mbp_stream_if.sv
// Purpose: Valid/ready word stream between block modules
// Assumes: Single clock
// Notes: Source drives valid and data
interface mbp_stream_if;
  mbp_pkg::mbp_word_t data;
  logic valid;
  logic ready;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : mbp_stream_if

// ### test/mbp_fifo_mem_model.sv
// Purpose: Behavioural FIFO memory behind the block
// Assumes: Whole words, random stalls
// Notes: An offered word holds until taken
module mbp_fifo_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clr_n,
  input wire mbp_pkg::mbp_word_t wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output mbp_pkg::mbp_word_t mem_word,
  output logic mem_valid,
  input wire logic mem_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import mbp_pkg::*;
  mbp_word_t store [$];
  logic hold;
  initial begin
    {wr_ready, mem_valid, mem_word} = '0;
  end
  always @(posedge clk) begin
    hold = mem_valid && !mem_ready;
    if (mem_valid && mem_ready) begin
      void'(store.pop_front());
    end
    if (wr_valid && wr_ready) begin
      store.push_back(wr_data); // Whole words only
    end
    if (!rst_b || !clr_n) begin
      store.delete();
      hold = 1'b0;
    end
    #1;
    wr_ready = store.size() < 4;
    mem_valid = hold || (store.size() > 0 && $urandom_range(3, 0) != 0);
    mem_word = mem_valid ? store[0] : ~mem_word;
  end
endmodule : mbp_fifo_mem_model

// ### test/mbp_port_checker.sv
// Purpose: Pin checks on mbp_port
// Assumes: One clock, RST_B disables
// Notes: Flags show one cycle after the taking edge
module mbp_port_checker (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic FULL_RESET_N,
  input wire logic PARTIAL_CLEAR_N,
  input wire logic BUS_WIDTH_MATCH_SEL,
  input wire logic BYTE_SIZE_SEL,
  input wire logic PORT_A_SELECT_N,
  input wire logic PORT_A_DIR,
  input wire logic PORT_A_STROBE,
  input wire logic PORT_A_MAIL_SEL,
  input wire logic PORT_B_SELECT_N,
  input wire logic PORT_B_DIR,
  input wire logic PORT_B_STROBE,
  input wire logic PORT_B_MAIL_SEL,
  input wire mbp_pkg::mbp_word_t PORT_B_DATA_OUT,
  input wire logic MAIL_AB_FULL_N,
  input wire logic MAIL_BA_FULL_N,
  input wire logic FULL_OR_IN_READY,
  input wire logic FIFO_WR_VALID
);
  timeunit 1ns;
  timeprecision 1ps;
  import mbp_pkg::*;
  logic a_on, b_on, a_put, a_take, b_put, b_take, a_fifo, clr;
  assign a_on = !PORT_A_SELECT_N && PORT_A_STROBE;
  assign b_on = !PORT_B_SELECT_N && PORT_B_STROBE;
  assign a_put = a_on && PORT_A_MAIL_SEL && !PORT_A_DIR;
  assign a_take = a_on && PORT_A_MAIL_SEL && PORT_A_DIR;
  assign b_put = b_on && PORT_B_MAIL_SEL && !PORT_B_DIR;
  assign b_take = b_on && PORT_B_MAIL_SEL && PORT_B_DIR;
  assign a_fifo = a_on && !PORT_A_MAIL_SEL && !PORT_A_DIR;
  assign clr = !FULL_RESET_N || !PARTIAL_CLEAR_N;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);
  sequence s_ab_put;
    a_put && !b_take && MAIL_AB_FULL_N && !clr ##1 !b_take && !clr;
  endsequence
  sequence s_ba_put;
    b_put && !a_take && MAIL_BA_FULL_N && !clr ##1 !a_take && !clr;
  endsequence
  a_ab_put_flag: assert property (s_ab_put |=> !MAIL_AB_FULL_N)
    else $error("A-to-B flag did not fall");
  a_ba_put_flag: assert property (s_ba_put |=> !MAIL_BA_FULL_N)
    else $error("B-to-A flag did not fall");
  a_ab_take_flag: assert property (b_take && !a_put ##1 !a_put |=> MAIL_AB_FULL_N)
    else $error("A-to-B flag did not rise");
  a_ba_take_flag: assert property (a_take && !b_put ##1 !b_put |=> MAIL_BA_FULL_N)
    else $error("B-to-A flag did not rise");
  a_b_mail_lanes: assert property (b_take && BUS_WIDTH_MATCH_SEL |=>
    PORT_B_DATA_OUT[35:18] == '0 && (!BYTE_SIZE_SEL || PORT_B_DATA_OUT[17:9] == '0))
    else $error("mail read outside size lanes");
  a_fifo_take: assert property (a_fifo && FULL_OR_IN_READY && !clr |=> FIFO_WR_VALID)
    else $error("accepted FIFO write not passed on");
  a_fifo_drop: assert property (!FULL_OR_IN_READY |=> !FIFO_WR_VALID)
    else $error("FIFO write passed while not ready");
  a_clear_flags: assert property (clr [*2] |=> MAIL_AB_FULL_N && MAIL_BA_FULL_N)
    else $error("mail flags low after reset");
endmodule : mbp_port_checker

bind mbp_port mbp_port_checker i_chk (.*);

// ### test/mbp_port_tb.sv
// Purpose: Self-checking bench for mbp_port
// Assumes: mbp_fifo_mem_model plays the memory
// Notes: Six size and endian setups, then a partial clear
module mbp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mbp_pkg::*;
  logic CLOCK, RST_B, FULL_RESET_N, PARTIAL_CLEAR_N, BIG_ENDIAN_SEL;
  logic BUS_WIDTH_MATCH_SEL, BYTE_SIZE_SEL, PORT_A_DATA_OE, PORT_B_DATA_OE;
  logic PORT_A_SELECT_N, PORT_A_DIR, PORT_A_STROBE, PORT_A_MAIL_SEL;
  logic PORT_B_SELECT_N, PORT_B_DIR, PORT_B_STROBE, PORT_B_MAIL_SEL;
  logic MAIL_AB_FULL_N, MAIL_BA_FULL_N, FULL_OR_IN_READY, EMPTY_OR_OUT_READY;
  logic FIFO_WR_VALID, FIFO_WR_READY, MEM_VALID, MEM_READY, bm, sz, be;
  mbp_word_t PORT_A_DATA_IN, PORT_A_DATA_OUT, PORT_B_DATA_IN, PORT_B_DATA_OUT;
  mbp_word_t FIFO_WR_DATA, MEM_WORD, w, mask;
  mbp_word_t ws [3];
  int error_cnt, comparisons;

  mbp_port i_dut (.*);
  mbp_fifo_mem_model i_mem (.clk(CLOCK), .rst_b(RST_B), .clr_n(FULL_RESET_N & PARTIAL_CLEAR_N),
    .wr_data(FIFO_WR_DATA), .wr_valid(FIFO_WR_VALID), .wr_ready(FIFO_WR_READY),
    .mem_word(MEM_WORD), .mem_valid(MEM_VALID), .mem_ready(MEM_READY));

  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  task automatic chk(input mbp_word_t seen, input mbp_word_t exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic idle(input int n);
    {PORT_A_SELECT_N, PORT_A_STROBE, PORT_B_SELECT_N, PORT_B_STROBE} = 4'ha;
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : idle

  task automatic wait_hi(input bit out_side);
    for (int i = 0; i < 40; i++) begin
      if ((out_side ? EMPTY_OR_OUT_READY : FULL_OR_IN_READY) === 1'b1) return;
      idle(1);
    end
    error_cnt++;
    $display("[ERR] %0t flag wait ran out", $time);
    end_of_test();
  endtask : wait_hi

  // One access on port A or B, taken at the next edge
  task automatic acc(input bit b, input logic dir, input logic mail, input mbp_word_t d);
    {PORT_A_SELECT_N, PORT_A_STROBE, PORT_B_SELECT_N, PORT_B_STROBE} = b ? 4'h9 : 4'h6;
    {PORT_A_DIR, PORT_A_MAIL_SEL, PORT_B_DIR, PORT_B_MAIL_SEL} = {2{dir, mail}};
    PORT_A_DATA_IN = d;
    PORT_B_DATA_IN = d;
    @(posedge CLOCK);
    #1;
  endtask : acc

  function automatic mbp_word_t rnd();
    return {4'($urandom()), $urandom()};
  endfunction : rnd

  // Piece k of a stored word as Port B shows it
  function automatic mbp_word_t piece(mbp_word_t v, int k);
    if (!bm) return v;
    if (!be) k = (sz ? 3 : 1) - k;
    return sz ? (v >> (9 * (3 - k))) & 36'h1ff : (v >> (18 * (1 - k))) & 36'h3ffff;
  endfunction : piece

  initial begin
    {RST_B, FULL_RESET_N, PARTIAL_CLEAR_N, BUS_WIDTH_MATCH_SEL, BYTE_SIZE_SEL} = 5'hc;
    {PORT_A_SELECT_N, PORT_A_STROBE, PORT_B_SELECT_N, PORT_B_STROBE} = 4'ha;
    {PORT_A_DIR, PORT_A_MAIL_SEL, PORT_B_DIR, PORT_B_MAIL_SEL, BIG_ENDIAN_SEL} = 5'h0;
    {PORT_A_DATA_IN, PORT_B_DATA_IN} = '0;
    error_cnt = 0;
    comparisons = 0;
    void'($urandom(32'he4729fbd));
    idle(2);
    RST_B = 1'b1;
    for (int cfg = 0; cfg < 6; cfg++) begin
      {bm, sz, be} = {cfg >= 2, cfg >= 4, cfg[0]};
      mask = !bm ? '1 : sz ? 36'h1ff : 36'h3ffff;
      {BUS_WIDTH_MATCH_SEL, BYTE_SIZE_SEL, BIG_ENDIAN_SEL} = {bm, sz || cfg == 1, be};
      FULL_RESET_N = 1'b0;
      idle(1);
      chk(EMPTY_OR_OUT_READY, cfg != 0 && !be);
      idle(2);
      chk(EMPTY_OR_OUT_READY, 1'b0);
      chk(MAIL_AB_FULL_N & MAIL_BA_FULL_N, 1'b1);
      chk(FULL_OR_IN_READY, 1'b0);
      FULL_RESET_N = 1'b1;
      idle(1);
      BIG_ENDIAN_SEL = ~be;
      acc(0, 0, 0, rnd());
      chk(FIFO_WR_VALID, 1'b0);
      wait_hi(0);
      w = (cfg == 0) ? '1 : rnd();
      acc(0, 0, 1, w);
      acc(0, 0, 1, ~w);
      idle(2);
      chk(MAIL_AB_FULL_N, 1'b0);
      for (int r = 0; r < 2; r++) begin
        acc(1, 1, 1, rnd());
        chk(PORT_B_DATA_OUT, w & mask);
        chk({PORT_A_DATA_OE, PORT_B_DATA_OE}, 2'h1);
      end
      idle(2);
      chk(MAIL_AB_FULL_N, 1'b1);
      w = rnd();
      acc(1, 0, 1, w);
      acc(0, 1, 1, rnd());
      chk(PORT_A_DATA_OUT, w & mask);
      chk({PORT_A_DATA_OE, PORT_B_DATA_OE}, 2'h2);
      idle(2);
      chk(MAIL_BA_FULL_N, 1'b1);
      for (int i = 0; i < 3; i++) begin
        ws[i] = rnd();
        acc(0, 0, 0, ws[i]);
        chk(FIFO_WR_DATA, ws[i]);
        chk(FIFO_WR_VALID, 1'b1);
      end
      idle(12);
      chk(MEM_READY, 1'b0);
      for (int j = 0; j < 2; j++) begin
        for (int k = 0; k < (bm ? (sz ? 4 : 2) : 1); k++) begin
          wait_hi(1);
          acc(1, 1, 0, rnd());
          chk(PORT_B_DATA_OUT, piece(ws[j], k));
          idle(1);
        end
      end
      $display("test cfg %0d done", cfg);
    end
    acc(0, 0, 1, rnd());
    PARTIAL_CLEAR_N = 1'b0;
    idle(3);
    chk(MAIL_AB_FULL_N, 1'b1);
    PARTIAL_CLEAR_N = 1'b1;
    idle(2);
    $display("test partial clear done");
    end_of_test();
  end
endmodule : mbp_port_tb
